// [hw/erf_filter.sv]
`timescale 1ns/1ps
`default_nettype none

// Operation
// - CRC-error acceptance accepts every bad-CRC frame
// - Runt-error acceptance accepts every runt frame
// - CRC check aborts bad frames, else ignored
// - Runt rejection drops frames under 64 bytes
// - Unicast own and not-me address filters
// - Broadcast and multicast filters accept their cast
// - Enabled cast filters combine by OR
// - Hash index is DA CRC bits 28:23
// - Set hash entry accepts, clear entry ignored
// - Hash CRC uncomplemented, destination address only
// - Wake pattern: six ones, sixteen addresses
// - Pattern filter accepts on checksum and mode
// - Sixteen-bit offset places the 64-byte window
// - Window past frame end aborts frame
// - Mask bit n selects window byte n
// - Ones-complement sum, odd byte zero padded
// - Checksum accumulator starts at zero per frame
// - Fold carries until clear, then invert
// - Filters decide in fixed priority order
// - Frames nobody accepts are discarded
// - Decision made only after frame end
// - Status records matches of all filters
module erf_filter
    import erf_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Receive byte stream from the MAC
    input  wire logic        rx_valid,
    input  wire erf_rx_t     rx,
    // Keep or abort decision to the receive DMA
    output logic             dec_valid,
    output erf_dec_t         dec
);

    erf_cfg_t                   cfg_ff;
    logic [63:0]                ht_ff;
    logic [63:0]                pm_mask_ff;
    logic [15:0]                wofs_ff;
    logic [15:0]                ckref_ff;
    logic [ADDR_BYTES-1:0][7:0] sa_ff;
    logic [ADDR_BYTES-1:0][7:0] da_ff;
    logic [31:0]                prdata_ff;
    logic                       pready_ff;
    logic                       pslverr_ff;
    erf_fr_t                    st_ff;
    erf_fr_t                    nxt_st;
    logic [16:0]                len_ff;
    logic                       crc_ok_ff;
    logic [31:0]                crc_ff;
    logic [31:0]                acc_ff;
    logic [31:0]                nxt_acc;
    logic                       win_full_ff;
    erf_wk_t                    wk_ff;
    erf_wk_t                    nxt_wk;
    logic [2:0]                 sync_ff;
    logic [2:0]                 nxt_sync;
    logic [2:0]                 sel_ff;
    logic [2:0]                 nxt_sel;
    logic [3:0]                 rep_ff;
    logic [3:0]                 nxt_rep;
    logic                       dec_valid_ff;
    erf_dec_t                   dec_ff;
    erf_dec_t                   nxt_dec;

    logic        access;
    logic        wr_en;
    logic        mapped;
    logic [31:0] rd_mux;
    logic        first;
    logic        take;
    logic [16:0] idx;
    logic [16:0] rel;
    logic        in_win;
    logic [31:0] folded;
    logic [15:0] cks;
    logic        pm_ok;

    // Register bus: one wait state so that read data comes from a flop
    assign access = psel && penable;
    assign wr_en  = access && pready_ff && pwrite && !pslverr_ff;

    always_comb begin
        mapped = 1'b1;
        rd_mux = '0;
        case (paddr)
            OFS_CFG:   rd_mux = {16'h0000, cfg_ff};
            OFS_HT_LO: rd_mux = ht_ff[31:0];
            OFS_HT_HI: rd_mux = ht_ff[63:32];
            OFS_PM_LO: rd_mux = pm_mask_ff[31:0];
            OFS_PM_HI: rd_mux = pm_mask_ff[63:32];
            OFS_WOFS:  rd_mux = {16'h0000, wofs_ff};
            OFS_CKREF: rd_mux = {16'h0000, ckref_ff};
            OFS_SA_LO: rd_mux = sa_ff[3:0];
            OFS_SA_HI: rd_mux = {16'h0000, sa_ff[5:4]};
            OFS_RSV:   rd_mux = {22'h000000, dec_ff};
            default:   mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
        end else begin
            pready_ff  <= access && !pready_ff;
            pslverr_ff <= access && !pready_ff && !mapped;
            if (access && !pready_ff) begin
                prdata_ff <= (pwrite || !mapped) ? 32'h00000000 : rd_mux;
            end
        end
    end

    // Settings are meant to change only while reception is off; no interlock here
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_ff     <= '0;
            ht_ff      <= '0;
            pm_mask_ff <= '0;
            wofs_ff    <= '0;
            ckref_ff   <= '0;
            sa_ff      <= '0;
        end else if (wr_en) begin
            case (paddr)
                OFS_CFG:   cfg_ff           <= erf_cfg_t'(pwdata[15:0] & CFG_WMASK);
                OFS_HT_LO: ht_ff[31:0]      <= pwdata;
                OFS_HT_HI: ht_ff[63:32]     <= pwdata;
                OFS_PM_LO: pm_mask_ff[31:0] <= pwdata;
                OFS_PM_HI: pm_mask_ff[63:32] <= pwdata;
                OFS_WOFS:  wofs_ff          <= pwdata[15:0];
                OFS_CKREF: ckref_ff         <= pwdata[15:0];
                OFS_SA_LO: sa_ff[3:0]       <= pwdata;
                OFS_SA_HI: sa_ff[5:4]       <= pwdata[15:0];
                default:   ;
            endcase
        end
    end

    // Byte position within the frame and the pattern window
    assign first  = (st_ff == FR_IDLE);
    assign take   = rx_valid && (first ? rx.sof : (st_ff == FR_BODY));
    assign idx    = first ? 17'h00000 : len_ff;
    assign rel    = idx - {1'b0, wofs_ff};
    assign in_win = (idx >= {1'b0, wofs_ff}) && (rel < WIN_BYTES);

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            FR_IDLE:   if (take) nxt_st = rx.eof ? FR_DECIDE : FR_BODY;
            FR_BODY:   if (take && rx.eof) nxt_st = FR_DECIDE;
            FR_DECIDE: nxt_st = FR_IDLE;
            default:   nxt_st = FR_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_ff <= FR_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            len_ff    <= '0;
            crc_ok_ff <= 1'b0;
            da_ff     <= '0;
            crc_ff    <= CRC_INIT;
        end else if (take) begin
            len_ff <= (idx == LEN_MAX) ? idx : idx + 17'h00001;
            if (rx.eof) begin
                crc_ok_ff <= rx.crc_ok;
            end
            if (idx < ADDR_LEN) begin
                da_ff[idx[2:0]] <= rx.data;
                crc_ff <= erf_crc_byte(first ? CRC_INIT : crc_ff, rx.data);
            end
        end
    end

    // Window bytes land in the high or low half of a 16-bit word by position
    always_comb begin
        nxt_acc = first ? 32'h00000000 : acc_ff;
        if (in_win && pm_mask_ff[rel[5:0]]) begin
            nxt_acc = nxt_acc + (rel[0] ? {24'h000000, rx.data} : {16'h0000, rx.data, 8'h00});
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_ff      <= '0;
            win_full_ff <= 1'b0;
        end else if (st_ff == FR_DECIDE) begin
            acc_ff      <= '0;
            win_full_ff <= 1'b0;
        end else if (take) begin
            acc_ff      <= nxt_acc;
            win_full_ff <= (first ? 1'b0 : win_full_ff) || (in_win && (rel[5:0] == 6'h3f));
        end
    end

    // Wake-up pattern scanner; a station address that starts with all ones is ambiguous
    always_comb begin
        nxt_wk   = first ? WK_SYNC : wk_ff;
        nxt_sync = first ? 3'h0 : sync_ff;
        nxt_sel  = first ? 3'h0 : sel_ff;
        nxt_rep  = first ? 4'h0 : rep_ff;
        case (nxt_wk)
            WK_SYNC: begin
                if (nxt_sync == SYNC_BYTES && rx.data == sa_ff[0]) begin
                    nxt_wk  = WK_ADDR;
                    nxt_sel = 3'h1;
                    nxt_rep = 4'h0;
                end else if (rx.data == BYTE_ONES) begin
                    nxt_sync = (nxt_sync == SYNC_BYTES) ? nxt_sync : nxt_sync + 3'h1;
                end else begin
                    nxt_sync = 3'h0;
                end
            end
            WK_ADDR: begin
                if (rx.data == sa_ff[nxt_sel]) begin
                    if (nxt_sel == LAST_SEL) begin
                        nxt_sel = 3'h0;
                        if (nxt_rep == LAST_REP) begin
                            nxt_wk = WK_FOUND;
                        end else begin
                            nxt_rep = nxt_rep + 4'h1;
                        end
                    end else begin
                        nxt_sel = nxt_sel + 3'h1;
                    end
                end else begin
                    nxt_wk   = WK_SYNC;
                    nxt_sync = (rx.data == BYTE_ONES) ? 3'h1 : 3'h0;
                end
            end
            WK_FOUND: ;
            default:  nxt_wk = WK_SYNC;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wk_ff   <= WK_SYNC;
            sync_ff <= '0;
            sel_ff  <= '0;
            rep_ff  <= '0;
        end else if (take) begin
            wk_ff   <= nxt_wk;
            sync_ff <= nxt_sync;
            sel_ff  <= nxt_sel;
            rep_ff  <= nxt_rep;
        end
    end

    // Two folds suffice: 64 bytes cannot carry past bit 20
    assign folded = erf_fold(erf_fold(acc_ff));
    assign cks    = ~folded[15:0];

    // Match flags are formed whether or not each filter is enabled
    always_comb begin
        nxt_dec.receive_status_vector.crc_err = !crc_ok_ff;
        nxt_dec.receive_status_vector.runt    = (len_ff < MIN_FRAME_LEN);
        nxt_dec.receive_status_vector.bcast   = &da_ff;
        nxt_dec.receive_status_vector.group   = da_ff[0][GROUP_BIT] && !(&da_ff);
        nxt_dec.receive_status_vector.own     = !da_ff[0][GROUP_BIT] && (da_ff == sa_ff);
        nxt_dec.receive_status_vector.other   = !da_ff[0][GROUP_BIT] && (da_ff != sa_ff);
        nxt_dec.receive_status_vector.hash    = ht_ff[crc_ff[HASH_MSB:HASH_LSB]];
        nxt_dec.receive_status_vector.wake    = (wk_ff == WK_FOUND);
        case (cfg_ff.pattern_filter_mode)
            PM_OWN:   pm_ok = nxt_dec.receive_status_vector.own;
            PM_BCAST: pm_ok = nxt_dec.receive_status_vector.bcast;
            PM_HASH:  pm_ok = nxt_dec.receive_status_vector.hash;
            PM_WAKE:  pm_ok = nxt_dec.receive_status_vector.wake;
            default:  pm_ok = 1'b1;
        endcase
        nxt_dec.receive_status_vector.pattern = win_full_ff && pm_ok
                              && ((cks == ckref_ff) != cfg_ff.pattern_compare_invert);
        // Highest enabled filter that decides wins
        if (cfg_ff.crcerr_accept_en && nxt_dec.receive_status_vector.crc_err) begin
            nxt_dec.accept = 1'b1;
        end else if (cfg_ff.runterr_accept_en && nxt_dec.receive_status_vector.runt) begin
            nxt_dec.accept = 1'b1;
        end else if (cfg_ff.crc_check_en && nxt_dec.receive_status_vector.crc_err) begin
            nxt_dec.accept = 1'b0;
        end else if (cfg_ff.runt_reject_en && nxt_dec.receive_status_vector.runt) begin
            nxt_dec.accept = 1'b0;
        end else if ((cfg_ff.own_address_accept_en && nxt_dec.receive_status_vector.own)
                  || (cfg_ff.other_address_accept_en && nxt_dec.receive_status_vector.other)
                  || (cfg_ff.group_address_accept_en && nxt_dec.receive_status_vector.group)
                  || (cfg_ff.all_stations_accept_en && nxt_dec.receive_status_vector.bcast)) begin
            nxt_dec.accept = 1'b1;
        end else if (cfg_ff.hash_accept_en && nxt_dec.receive_status_vector.hash) begin
            nxt_dec.accept = 1'b1;
        end else if (cfg_ff.wake_accept_en && nxt_dec.receive_status_vector.wake) begin
            nxt_dec.accept = 1'b1;
        end else if (cfg_ff.pattern_filter_mode != PM_OFF) begin
            nxt_dec.accept = nxt_dec.receive_status_vector.pattern;
        end else begin
            nxt_dec.accept = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dec_valid_ff <= 1'b0;
            dec_ff       <= '0;
        end else begin
            dec_valid_ff <= (st_ff == FR_DECIDE);
            if (st_ff == FR_DECIDE) begin
                dec_ff <= nxt_dec;
            end
        end
    end

    assign prdata    = prdata_ff;
    assign pready    = pready_ff;
    assign pslverr   = pslverr_ff;
    assign dec_valid = dec_valid_ff;
    assign dec       = dec_ff;

    crcerr_accept_a: assert property (@(posedge clk) disable iff (sys_rst)
        dec_valid_ff && dec_ff.receive_status_vector.crc_err && $past(cfg_ff.crcerr_accept_en) |-> dec_ff.accept)
        else $error("Bad-CRC frame not accepted");

    runterr_accept_a: assert property (@(posedge clk) disable iff (sys_rst)
        dec_valid_ff && dec_ff.receive_status_vector.runt && $past(cfg_ff.runterr_accept_en) |-> dec_ff.accept)
        else $error("Runt frame not accepted");

    crc_reject_a: assert property (@(posedge clk) disable iff (sys_rst)
        dec_valid_ff && dec_ff.receive_status_vector.crc_err && $past(cfg_ff.crc_check_en)
        && !$past(cfg_ff.crcerr_accept_en) && !(dec_ff.receive_status_vector.runt && $past(cfg_ff.runterr_accept_en))
        |-> !dec_ff.accept)
        else $error("Bad-CRC frame kept");

    runt_reject_a: assert property (@(posedge clk) disable iff (sys_rst)
        (st_ff == FR_DECIDE) && (len_ff < MIN_FRAME_LEN) && cfg_ff.runt_reject_en
        && !cfg_ff.runterr_accept_en && !cfg_ff.crcerr_accept_en |=> !dec_ff.accept)
        else $error("Runt frame kept");

    cast_or_a: assert property (@(posedge clk) disable iff (sys_rst)
        dec_valid_ff && dec_ff.receive_status_vector.bcast && $past(cfg_ff.all_stations_accept_en)
        && !$past(cfg_ff.crc_check_en) && !$past(cfg_ff.runt_reject_en) |-> dec_ff.accept)
        else $error("Broadcast frame not accepted");

    acc_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        (st_ff == FR_DECIDE) |=> (acc_ff == 32'h00000000) && !win_full_ff)
        else $error("Checksum not cleared between frames");

    default_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
        (st_ff == FR_DECIDE) && (cfg_ff == '0) |=> dec_valid_ff && !dec_ff.accept)
        else $error("Frame kept with all filters off");

    end_decide_a: assert property (@(posedge clk) disable iff (sys_rst)
        take && rx.eof |=> !dec_valid_ff ##1 dec_valid_ff ##1 !dec_valid_ff)
        else $error("Decision not two cycles after frame end");

endmodule : erf_filter
`default_nettype wire

// [shared/erf_pkg.sv]
`default_nettype none
package erf_pkg;

    // Register byte addresses
    localparam logic [7:0] OFS_CFG   = 8'h00;
    localparam logic [7:0] OFS_HT_LO = 8'h04;
    localparam logic [7:0] OFS_HT_HI = 8'h08;
    localparam logic [7:0] OFS_PM_LO = 8'h0c;
    localparam logic [7:0] OFS_PM_HI = 8'h10;
    localparam logic [7:0] OFS_WOFS  = 8'h14;
    localparam logic [7:0] OFS_CKREF = 8'h18;
    localparam logic [7:0] OFS_SA_LO = 8'h1c;
    localparam logic [7:0] OFS_SA_HI = 8'h20;
    localparam logic [7:0] OFS_RSV   = 8'h24;

    // Bit 13 of the configuration is reserved and reads zero
    localparam logic [15:0] CFG_WMASK = 16'hdfff;

    // Frame and window figures
    localparam logic [16:0] MIN_FRAME_LEN = 17'h00040;
    localparam logic [16:0] WIN_BYTES     = 17'h00040;
    localparam logic [16:0] LEN_MAX       = 17'h1ffff;
    localparam logic [16:0] ADDR_LEN      = 17'h00006;
    localparam int          ADDR_BYTES    = 6;
    localparam int          GROUP_BIT     = 0;
    localparam int          HASH_LSB      = 23;
    localparam int          HASH_MSB      = 28;

    // Wake-up pattern figures
    localparam logic [2:0] SYNC_BYTES = 3'h6;
    localparam logic [2:0] LAST_SEL   = 3'h5;
    localparam logic [3:0] LAST_REP   = 4'hf;
    localparam logic [7:0] BYTE_ONES  = 8'hff;

    // Destination address CRC, reflected, left uncomplemented
    localparam logic [31:0] CRC_POLY = 32'hedb88320;
    localparam logic [31:0] CRC_INIT = 32'hffffffff;

    // Pattern filter modes
    localparam logic [3:0] PM_OFF   = 4'h0;
    localparam logic [3:0] PM_CKS   = 4'h1;
    localparam logic [3:0] PM_OWN   = 4'h2;
    localparam logic [3:0] PM_BCAST = 4'h3;
    localparam logic [3:0] PM_HASH  = 4'h4;
    localparam logic [3:0] PM_WAKE  = 4'h5;

    typedef struct packed {
        logic       hash_accept_en;
        logic       wake_accept_en;
        logic       rsvd;
        logic       pattern_compare_invert;
        logic [3:0] pattern_filter_mode;
        logic       crcerr_accept_en;
        logic       crc_check_en;
        logic       runterr_accept_en;
        logic       runt_reject_en;
        logic       own_address_accept_en;
        logic       other_address_accept_en;
        logic       group_address_accept_en;
        logic       all_stations_accept_en;
    } erf_cfg_t;

    typedef struct packed {
        logic       sof;
        logic       eof;
        logic       crc_ok;
        logic [7:0] data;
    } erf_rx_t;

    typedef struct packed {
        logic crc_err;
        logic runt;
        logic own;
        logic other;
        logic group;
        logic bcast;
        logic hash;
        logic wake;
        logic pattern;
    } erf_rsv_t;

    typedef struct packed {
        logic     accept;
        erf_rsv_t receive_status_vector;
    } erf_dec_t;

    typedef enum logic [1:0] {FR_IDLE = 2'b00, FR_BODY = 2'b01, FR_DECIDE = 2'b11} erf_fr_t;
    typedef enum logic [1:0] {WK_SYNC = 2'b00, WK_ADDR = 2'b01, WK_FOUND = 2'b11} erf_wk_t;

    function automatic logic [31:0] erf_crc_byte(input logic [31:0] crc, input logic [7:0] b);
        logic [31:0] c;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            c = (c[0] ^ b[i]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : erf_crc_byte

    function automatic logic [31:0] erf_fold(input logic [31:0] x);
        return {16'h0000, x[15:0]} + {16'h0000, x[31:16]};
    endfunction : erf_fold

endpackage : erf_pkg
`default_nettype wire

// [sim/erf_filter_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module erf_filter_tb import erf_pkg::*; ;
    logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, rx_valid, dec_valid, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    erf_rx_t     rx;
    erf_dec_t    dec;
    logic [47:0] sa, ou, da;
    logic [63:0] mask;
    logic [15:0] ref_ck;
    logic [7:0]  f[$];
    int          miscompares, n_tests, cyc, off;

    erf_filter u_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_valid(rx_valid), .rx(rx), .dec_valid(dec_valid), .dec(dec));
    erf_mac_model u_mac (.clk(clk), .rx_valid(rx_valid), .rx(rx));

    task automatic test_done();
        if (miscompares == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %0t register got %h expected %h", $time, g, e);
        end
    endtask : chk32

    task automatic chk1(input logic g, input logic e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %0t decision got %b expected %b", $time, g, e);
        end
    endtask : chk1

    // Master waits on pready, never on a fixed count
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk);
        while (pready !== 1'b1);
        rd      = prdata;
        er      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic mk(input logic [47:0] d, input int n);
        f.delete();
        for (int i = 0; i < n; i++) f.push_back(i < 6 ? d[8*i+:8] : 8'($urandom));
    endtask : mk

    // Decision stands in the cycle after the edge that follows the end-of-frame edge
    task automatic frame(input logic ok, input logic exp);
        u_mac.send(f, ok);
        #1 chk1(dec_valid, 1'b0);
        @(posedge clk);
        #1 chk1(dec_valid, 1'b1);
        chk1(dec.accept, exp);
    endtask : frame

    task automatic tcase(input logic [31:0] c, input logic [47:0] d, input int n, input logic ok, input logic e);
        apb(1'b1, OFS_CFG, c);
        mk(d, n);
        frame(ok, e);
    endtask : tcase

    function automatic logic [5:0] hidx(input logic [47:0] d);
        logic [31:0] c;
        logic        fb;
        c = '1;
        for (int i = 0; i < 48; i++) begin
            fb = c[0] ^ d[i];
            c  = c >> 1;
            if (fb) c = c ^ CRC_POLY;
        end
        return c[28:23];
    endfunction : hidx

    // Positional pairing: even window byte high, odd low, unselected bytes count as zero
    function automatic logic [15:0] cks(input int o, input logic [63:0] m);
        logic [31:0] a;
        a = 32'h0;
        for (int n = 0; n < 64; n += 2)
            a = a + {16'h0, (m[n] ? f[o+n] : 8'h00), (m[n+1] ? f[o+n+1] : 8'h00)};
        while (a[31:16] != 16'h0) a = {16'h0, a[15:0]} + {16'h0, a[31:16]};
        return ~a[15:0];
    endfunction : cks

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            miscompares++;
            test_done();
        end
    end

    initial begin
        {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {miscompares, n_tests, cyc} = '0;
        void'($urandom(32'h90ae2624));
        sa = {16'($urandom), $urandom} & ~48'h1;
        ou = sa ^ 48'h100;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        apb(1'b0, OFS_HT_LO, 32'h0); chk32(rd, 32'h0);
        apb(1'b1, OFS_CFG, '1); apb(1'b0, OFS_CFG, 32'h0); chk32(rd, {16'h0, CFG_WMASK});
        apb(1'b1, 8'h28, 32'h1); chk32({31'h0, er}, 32'h1);
        apb(1'b1, OFS_SA_LO, sa[31:0]);
        apb(1'b1, OFS_SA_HI, {16'h0, sa[47:32]});
        tcase(32'h0008, sa, 64, 1'b1, 1'b1);
        tcase(32'h0008, ou, 70, 1'b1, 1'b0);
        tcase(32'h0004, ou, 65, 1'b1, 1'b1);
        tcase(32'h0004, sa, 64, 1'b1, 1'b0);
        tcase(32'h0001, '1, 64, 1'b1, 1'b1);
        tcase(32'h0002, ou | 48'h1, 90, 1'b1, 1'b1);
        tcase(32'h0009, '1, 64, 1'b1, 1'b1);
        tcase(32'h000f, ou, 64, 1'b1, 1'b1);
        tcase(32'h004f, ou, 64, 1'b0, 1'b0);
        tcase(32'h000f, ou, 64, 1'b0, 1'b1);
        tcase(32'h00cf, ou, 64, 1'b0, 1'b1);
        tcase(32'h001f, ou, 63, 1'b1, 1'b0);
        tcase(32'h001f, ou, 64, 1'b1, 1'b1);
        tcase(32'h0060, ou, 40, 1'b0, 1'b1);
        tcase(32'h0000, '1, 64, 1'b1, 1'b0);
        apb(1'b0, OFS_RSV, 32'h0); chk32(rd & 32'h3fe, 32'h008);
        da = {16'($urandom), $urandom};
        mask = 64'h1 << hidx(da);
        apb(1'b1, OFS_HT_LO, mask[31:0]);
        apb(1'b1, OFS_HT_HI, mask[63:32]);
        tcase(32'h8000, da, 64, 1'b1, 1'b1);
        apb(1'b1, OFS_HT_LO, ~mask[31:0]);
        apb(1'b1, OFS_HT_HI, ~mask[63:32]);
        tcase(32'h8000, da, 64, 1'b1, 1'b0);
        mk(sa, 80);
        off = $urandom_range(0, 16);
        mask = {$urandom, $urandom};
        ref_ck = cks(off, mask);
        apb(1'b1, OFS_PM_LO, mask[31:0]);
        apb(1'b1, OFS_PM_HI, mask[63:32]);
        apb(1'b1, OFS_WOFS, 32'(off));
        apb(1'b1, OFS_CKREF, {16'h0, ref_ck});
        apb(1'b1, OFS_CFG, 32'h0100); frame(1'b1, 1'b1);
        apb(1'b1, OFS_CFG, 32'h1100); frame(1'b1, 1'b0);
        apb(1'b1, OFS_WOFS, 32'd16); frame(1'b1, cks(16, mask) != ref_ck);
        apb(1'b1, OFS_WOFS, 32'd17); frame(1'b1, 1'b0);
        apb(1'b1, OFS_WOFS, 32'(off));
        apb(1'b1, OFS_CFG, 32'h0200); frame(1'b1, 1'b1);
        apb(1'b1, OFS_CFG, 32'h0300); frame(1'b1, 1'b0);
        apb(1'b1, OFS_CFG, 32'h0500); frame(1'b1, 1'b0);
        apb(1'b1, OFS_HT_LO, '1);
        apb(1'b1, OFS_HT_HI, '1);
        apb(1'b1, OFS_CFG, 32'h0400); frame(1'b1, 1'b1);
        apb(1'b1, OFS_CFG, 32'h1000); frame(1'b1, 1'b0);
        mk(sa, 10);
        for (int i = 0; i < 6; i++) f.push_back(BYTE_ONES);
        for (int i = 0; i < 96; i++) f.push_back(sa[8*(i%6)+:8]);
        for (int i = 0; i < 8; i++) f.push_back(8'h00);
        apb(1'b1, OFS_CFG, 32'h4000); frame(1'b1, 1'b1);
        f[50] = ~f[50];
        frame(1'b1, 1'b0);
        test_done();
    end
endmodule : erf_filter_tb
`default_nettype wire

// [sim/erf_mac_model.sv]
`timescale 1ns/1ps
`default_nettype none
module erf_mac_model
    import erf_pkg::*;
(
    // Clock
    input  wire logic clk,
    // Byte stream towards the filter
    output logic      rx_valid,
    output erf_rx_t   rx
);
    initial begin
        rx_valid = 1'b0;
        rx       = '0;
    end
    // Idle lines show the inverse of the last byte so a stale value never passes
    task automatic send(input logic [7:0] f[$], input logic ok);
        for (int i = 0; i < f.size(); i++) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx       <= '{sof: i == 0, eof: i == f.size() - 1, crc_ok: ok, data: f[i]};
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx       <= '{sof: 1'b0, eof: 1'b0, crc_ok: ~ok, data: ~f[f.size() - 1]};
    endtask : send
endmodule : erf_mac_model
`default_nettype wire
